// File: design/char_rx.sv
// Serial character receiver with parity, stop-bit check and idle-gap detection.
`default_nettype none

module char_rx
    import relay_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Line and framing setup
    input  wire logic        rxd,
    input  wire logic [15:0] bit_div,
    input  wire logic [1:0]  parity_mode,
    input  wire logic        two_stop,
    // Received characters
    output logic             char_valid,
    output logic [7:0]       char_data,
    output logic             char_perr,
    output logic             char_ferr,
    output logic             gap_done
);
    typedef enum logic [4:0] {
        RX_IDLE  = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA  = 5'b00100,
        RX_PAR   = 5'b01000,
        RX_STOP  = 5'b10000
    } rx_state_t;

    typedef struct packed {
        rx_state_t   st;
        logic [15:0] cnt;
        logic [2:0]  nbit;
        logic        stop2;
        logic [7:0]  sh;
        logic        par;
        logic        valid;
        logic        perr;
        logic        ferr;
        logic [5:0]  gap;
        logic        armed;
        logic        gap_done;
    } rx_t;

    rx_t r;
    rx_t next_r;

    always_comb begin
        next_r          = r;
        next_r.valid    = 1'b0;
        next_r.gap_done = 1'b0;
        if (r.cnt != 16'h0000) begin
            next_r.cnt = r.cnt - 16'h0001;
        end
        unique case (r.st)
            RX_IDLE: begin
                if (!rxd) begin
                    next_r.st  = RX_START;
                    next_r.cnt = {1'b0, bit_div[15:1]};
                    next_r.gap = 6'h00;
                end else if (r.cnt == 16'h0000) begin
                    // Idle time is measured in whole bit periods after a character.
                    next_r.cnt = bit_div - 16'h0001;
                    if (r.armed) begin
                        next_r.gap = r.gap + 6'h01;
                        if (r.gap == GAP_BITS - 6'h01) begin
                            next_r.gap_done = 1'b1;
                            next_r.armed    = 1'b0;
                        end
                    end
                end
            end
            RX_START: begin
                if (r.cnt == 16'h0000) begin
                    if (rxd) begin
                        next_r.st = RX_IDLE;
                    end else begin
                        next_r.st   = RX_DATA;
                        next_r.cnt  = bit_div - 16'h0001;
                        next_r.nbit = 3'h0;
                        next_r.par  = 1'b0;
                        next_r.perr = 1'b0;
                        next_r.ferr = 1'b0;
                    end
                end
            end
            RX_DATA: begin
                if (r.cnt == 16'h0000) begin
                    next_r.sh    = {rxd, r.sh[7:1]};
                    next_r.par   = r.par ^ rxd;
                    next_r.cnt   = bit_div - 16'h0001;
                    next_r.nbit  = r.nbit + 3'h1;
                    next_r.stop2 = two_stop;
                    if (r.nbit == 3'h7) begin
                        next_r.st = (parity_mode == PAR_ODD || parity_mode == PAR_EVEN)
                                  ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (r.cnt == 16'h0000) begin
                    next_r.perr = (r.par ^ rxd) != (parity_mode == PAR_ODD);
                    next_r.cnt  = bit_div - 16'h0001;
                    next_r.st   = RX_STOP;
                end
            end
            RX_STOP: begin
                if (r.cnt == 16'h0000) begin
                    next_r.ferr = r.ferr | ~rxd;
                    next_r.cnt  = bit_div - 16'h0001;
                    if (r.stop2 && rxd) begin
                        next_r.stop2 = 1'b0;
                    end else begin
                        next_r.valid = 1'b1;
                        next_r.st    = RX_IDLE;
                        next_r.armed = 1'b1;
                    end
                end
            end
            default: next_r.st = RX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{st: RX_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign char_valid = r.valid;
    assign char_data  = r.sh;
    assign char_perr  = r.perr;
    assign char_ferr  = r.ferr;
    assign gap_done   = r.gap_done;
endmodule

`default_nettype wire

// File: design/relay_ctrl_pkg.sv
// Shared constants for the relay output controller and its helpers.
`default_nettype none

package relay_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_OUT_ACTUAL  = 8'h04;
    localparam logic [7:0]  IDX_OUT_CMD     = 8'h0A;
    localparam logic [7:0]  IDX_TIMEOUT     = 8'h4E;
    localparam logic [7:0]  IDX_INIT        = 8'h5C;
    localparam logic [7:0]  IDX_COMM        = 8'h5D;
    localparam logic [7:0]  IDX_BAUD        = 8'h5E;
    localparam logic [7:0]  IDX_COMMAND     = 8'h78;
    localparam logic [7:0]  IDX_LINK_STATUS = 8'h80;

    // ------------------------------------------------------------------
    // Reset values, masks and codes
    // ------------------------------------------------------------------
    localparam logic [15:0] TIMEOUT_RST     = 16'h0000;
    localparam logic [15:0] INIT_RST        = 16'h0000;
    localparam logic [15:0] COMM_RST        = 16'h0100;
    localparam logic [2:0]  BAUD_RST        = 3'h3;
    localparam logic [15:0] INIT_MASK       = 16'hC0FF;
    localparam logic [15:0] COMM_MASK       = 16'hFF07;
    localparam logic [15:0] CMD_FACTORY     = 16'hFAC7;

    // ------------------------------------------------------------------
    // Field positions and parity codes
    // ------------------------------------------------------------------
    localparam int          INIT_TMO_BIT    = 14;
    localparam int          INIT_RETAIN_BIT = 15;
    localparam int          COMM_STOP_BIT   = 2;
    localparam logic [1:0]  PAR_NONE        = 2'h0;
    localparam logic [1:0]  PAR_ODD         = 2'h1;
    localparam logic [1:0]  PAR_EVEN        = 2'h2;
    localparam int          ST_FRAME        = 0;
    localparam int          ST_PARITY       = 1;
    localparam int          ST_FRAMING      = 2;
    localparam int          ST_TIMEOUT      = 3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ_DEF      = 50_000_000;
    localparam int          MS_PER_S        = 1000;
    localparam int          TENTH_MS        = 100;
    localparam int          BAUD_TABLE [8]  = '{1200, 2400, 4800, 9600,
                                                19200, 38400, 57600, 115200};
    localparam logic [5:0]  GAP_BITS        = 6'h26;
    localparam logic [1:0]  SYNC_SETTLE     = 2'h3;

endpackage

`default_nettype wire

// File: design/relay_output_ctrl.sv
// Relay output controller: APB registers, serial frame watch, timeout and retention.
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`default_nettype none

module relay_output_ctrl
    import relay_ctrl_pkg::*;
#(
    parameter int CLK_HZ       = CLK_HZ_DEF,
    parameter int TENTH_CYCLES = CLK_HZ / (MS_PER_S / TENTH_MS)
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial line
    input  wire logic        rxd,
    // Nonvolatile store
    input  wire logic [7:0]  nv_outputs_in,
    input  wire logic [15:0] nv_init_in,
    output logic             nv_write,
    output logic      [7:0]  nv_data,
    // Relay drive
    output logic      [7:0]  relay_out
);
    localparam logic [31:0] TENTH_TOP = 32'(TENTH_CYCLES - 1);

    typedef enum logic [2:0] {
        PH_SETTLE = 3'b001,
        PH_LOAD   = 3'b010,
        PH_RUN    = 3'b100
    } phase_t;

    typedef struct packed {
        phase_t      ph;
        logic [1:0]  settle;
        logic [15:0] init_word;
        logic [15:0] comm;
        logic [15:0] timeout;
        logic [2:0]  baud;
        logic [7:0]  out_cmd;
        logic [3:0]  stat;
        logic [31:0] tick;
        logic [15:0] tenths;
        logic        tmo_armed;
        logic        frm_first;
        logic        frm_ok;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        nv_write;
        logic [7:0]  nv_data;
    } ctl_t;

    ctl_t        r;
    ctl_t        next_r;
    logic        rxd_s;
    logic [23:0] nv_s;
    logic [15:0] bit_div;
    logic        char_valid;
    logic [7:0]  char_data;
    logic        char_perr;
    logic        char_ferr;
    logic        gap_done;
    logic        tmo_en;
    logic        expire;
    logic        frame_hit;

    // -------------------------------------------------------------------------
    // Input synchronisers and character receiver
    // -------------------------------------------------------------------------
    sync2 #(.W(1), .RST_VAL(1'b1)) u_sync_rxd (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (rxd),
        .q       (rxd_s)
    );

    sync2 #(.W(24), .RST_VAL(24'h000000)) u_sync_nv (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({nv_init_in, nv_outputs_in}),
        .q       (nv_s)
    );

    function automatic logic [15:0] divisor(input logic [2:0] sel);
        logic [15:0] d;
        d = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            if (sel == 3'(i)) begin
                d = 16'(CLK_HZ / BAUD_TABLE[i]);
            end
        end
        return d;
    endfunction

    assign bit_div = divisor(r.baud);

    char_rx u_rx (
        .pclk        (pclk),
        .presetn     (presetn),
        .rxd         (rxd_s),
        .bit_div     (bit_div),
        .parity_mode (r.comm[1:0]),
        .two_stop    (r.comm[COMM_STOP_BIT]),
        .char_valid  (char_valid),
        .char_data   (char_data),
        .char_perr   (char_perr),
        .char_ferr   (char_ferr),
        .gap_done    (gap_done)
    );

    // -------------------------------------------------------------------------
    // Control logic
    // -------------------------------------------------------------------------
    assign tmo_en    = r.ph == PH_RUN && r.init_word[INIT_TMO_BIT] && r.tmo_armed
                       && r.timeout != 16'h0000;
    // Compare with >= so that shortening the timeout below the elapsed time still expires.
    assign expire    = tmo_en && r.tick == TENTH_TOP && r.tenths >= r.timeout - 16'h0001;
    assign frame_hit = gap_done && !r.frm_first && r.frm_ok;

    always_comb begin
        logic [31:0] rd;
        logic        hit;
        logic        wr;
        rd              = 32'h00000000;
        hit             = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;
        wr              = 1'b0;
        next_r          = r;
        next_r.nv_write = 1'b0;
        unique case (r.ph)
            PH_SETTLE: begin
                if (r.settle == SYNC_SETTLE) begin
                    next_r.ph = PH_LOAD;
                end else begin
                    next_r.settle = r.settle + 2'h1;
                end
            end
            PH_LOAD: begin
                next_r.init_word = nv_s[23:8] & INIT_MASK;
                next_r.out_cmd   = nv_s[8 + INIT_RETAIN_BIT] ? nv_s[7:0] : nv_s[15:8];
                next_r.ph        = PH_RUN;
            end
            PH_RUN: begin
                wr = psel && penable && r.pready && pwrite;
            end
            default: next_r.ph = PH_SETTLE;
        endcase

        // Timer runs in tenths of a second while enabled and restarts on a good frame.
        if (!tmo_en) begin
            next_r.tick   = 32'h00000000;
            next_r.tenths = 16'h0000;
        end else if (expire) begin
            next_r.out_cmd   = r.init_word[7:0];
            next_r.tmo_armed = 1'b0;
        end else if (r.tick == TENTH_TOP) begin
            next_r.tick   = 32'h00000000;
            next_r.tenths = r.tenths + 16'h0001;
        end else begin
            next_r.tick = r.tick + 32'h00000001;
        end

        // A frame counts only if its first character matches the slave address.
        if (char_valid) begin
            next_r.frm_first = 1'b0;
            if (r.frm_first) begin
                next_r.frm_ok = !(char_perr || char_ferr) && char_data == r.comm[15:8];
            end else begin
                next_r.frm_ok = r.frm_ok && !(char_perr || char_ferr);
            end
        end
        if (gap_done) begin
            next_r.frm_first = 1'b1;
        end
        if (frame_hit) begin
            next_r.tick      = 32'h00000000;
            next_r.tenths    = 16'h0000;
            next_r.tmo_armed = 1'b1;
        end

        // Register decode; a bus write overrides a timeout fallback in the same cycle.
        case (paddr[9:2])
            IDX_OUT_ACTUAL: rd = {24'h000000, r.out_cmd};
            IDX_OUT_CMD: begin
                rd = {24'h000000, r.out_cmd};
                if (wr && hit) begin
                    next_r.out_cmd = pwdata[7:0];
                end
            end
            IDX_TIMEOUT: begin
                rd = {16'h0000, r.timeout};
                if (wr && hit) begin
                    next_r.timeout = pwdata[15:0];
                end
            end
            IDX_INIT: begin
                rd = {16'h0000, r.init_word};
                if (wr && hit) begin
                    next_r.init_word = pwdata[15:0] & INIT_MASK;
                end
            end
            IDX_COMM: begin
                rd = {16'h0000, r.comm};
                if (wr && hit) begin
                    next_r.comm = pwdata[15:0] & COMM_MASK;
                end
            end
            IDX_BAUD: begin
                rd = {29'h00000000, r.baud};
                if (wr && hit) begin
                    next_r.baud = pwdata[2:0];
                end
            end
            IDX_COMMAND: begin
                if (wr && hit && pwdata[15:0] == CMD_FACTORY) begin
                    next_r.timeout   = TIMEOUT_RST;
                    next_r.init_word = INIT_RST;
                    next_r.comm      = COMM_RST;
                    next_r.baud      = BAUD_RST;
                end
            end
            IDX_LINK_STATUS: begin
                rd = {28'h0000000, r.stat};
                if (wr && hit) begin
                    next_r.stat = r.stat & ~pwdata[3:0];
                end
            end
            default: hit = 1'b0;
        endcase

        // Sticky events are set after the clear so that a simultaneous event wins.
        if (char_valid && char_perr) begin
            next_r.stat[ST_PARITY] = 1'b1;
        end
        if (char_valid && char_ferr) begin
            next_r.stat[ST_FRAMING] = 1'b1;
        end
        if (frame_hit) begin
            next_r.stat[ST_FRAME] = 1'b1;
        end
        if (expire) begin
            next_r.stat[ST_TIMEOUT] = 1'b1;
        end

        next_r.pready  = psel && !r.pready && r.ph == PH_RUN;
        next_r.pslverr = psel && !r.pready && r.ph == PH_RUN && !hit;
        next_r.prdata  = hit ? rd : 32'h00000000;

        if (r.ph == PH_RUN && r.init_word[INIT_RETAIN_BIT] && next_r.out_cmd != r.out_cmd) begin
            next_r.nv_write = 1'b1;
            next_r.nv_data  = next_r.out_cmd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{ph: PH_SETTLE, comm: COMM_RST, baud: BAUD_RST, timeout: TIMEOUT_RST,
                   init_word: INIT_RST, tmo_armed: 1'b1, frm_first: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign prdata    = r.prdata;
    assign pready    = r.pready;
    assign pslverr   = r.pslverr;
    assign nv_write  = r.nv_write;
    assign nv_data   = r.nv_data;
    assign relay_out = r.out_cmd;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_read_actual;
        psel && !penable && !pwrite && paddr == {2'h0, IDX_OUT_ACTUAL, 2'h0}
            && !r.pready && r.ph == PH_RUN;
    endsequence

    sequence s_factory_write;
        psel && penable && pwrite && r.pready && r.ph == PH_RUN
            && paddr == {2'h0, IDX_COMMAND, 2'h0} && pwdata[15:0] == CMD_FACTORY;
    endsequence

    a_baud_div_range: assert property (bit_div >= 16'(CLK_HZ / 115200)
        && bit_div <= 16'(CLK_HZ / 1200)) else $error("bit divisor out of range");
    a_parity_sticky: assert property (char_valid && char_perr |=> r.stat[ST_PARITY])
        else $error("parity error not held");
    a_framing_sticky: assert property (char_valid && char_ferr |=> r.stat[ST_FRAMING])
        else $error("framing error not flagged");
    a_frame_restart: assert property (frame_hit |=> r.stat[ST_FRAME] && r.tick == 32'h0
        && r.tenths == 16'h0) else $error("addressed frame did not restart timer");
    a_foreign_ignored: assert property (gap_done && !r.frm_ok && r.tick != TENTH_TOP && tmo_en
        |=> r.tick != 32'h0) else $error("foreign frame restarted timer");
    a_factory_reset: assert property (s_factory_write |=> r.comm == COMM_RST
        && r.baud == BAUD_RST && r.init_word == INIT_RST && r.timeout == TIMEOUT_RST)
        else $error("factory default not applied");
    a_timeout_fall: assert property (expire && !(psel && penable && pwrite)
        |=> relay_out == $past(r.init_word[7:0]) && r.stat[ST_TIMEOUT])
        else $error("timeout fallback missing");
    a_zero_disable: assert property ((r.timeout == 16'h0)[*2] |-> r.tick == 32'h0 && !expire)
        else $error("timer ran with zero timeout");
    a_tick_bound: assert property (r.tick <= TENTH_TOP)
        else $error("tenth counter overran");
    a_retain_write: assert property ($changed(r.out_cmd) && $past(r.ph) == PH_RUN
        && $past(r.init_word[INIT_RETAIN_BIT]) |-> nv_write && nv_data == relay_out)
        else $error("output change not stored");
    a_power_restore: assert property (r.ph == PH_LOAD && nv_s[8 + INIT_RETAIN_BIT]
        |=> relay_out == $past(nv_s[7:0])) else $error("stored outputs not restored");
    a_actual_read: assert property (s_read_actual |=> pready && prdata == {24'h0, $past(r.out_cmd)})
        else $error("actual output read wrong");
endmodule

`default_nettype wire

// File: design/sync2.sv
// Two-stage synchroniser for signals from outside the clock domain.
`default_nettype none

module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_t;

    sync_t r;
    sync_t next_r;

    always_comb begin
        next_r.meta = d;
        next_r.q    = r.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= {RST_VAL, RST_VAL};
        end else begin
            r <= next_r;
        end
    end

    assign q = r.q;
endmodule

`default_nettype wire

// File: tb/modbus_master_model.sv
// Serial bus master model that sends request frames on the receive line.
`default_nettype none

module modbus_master_model
    import relay_ctrl_pkg::*;
#(
    parameter int DIV = 8
) (
    // Clock
    input  wire logic pclk,
    // Serial line, idle high between frames
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ns;

    initial rxd = 1'b1;

    task automatic put(input logic b);
        rxd <= b;
        repeat (DIV) @(posedge pclk);
    endtask

    // The gap after the frame exceeds the idle span that closes a frame.
    task automatic frame(input logic [7:0] a, input logic [1:0] par, input logic two);
        logic [7:0] c [2];
        c = '{a, 8'h06};
        foreach (c[i]) begin
            put(1'b0);
            for (int k = 0; k < 8; k++) put(c[i][k]);
            if (par == PAR_ODD) put(~^c[i]);
            else if (par == PAR_EVEN) put(^c[i]);
            put(1'b1);
            if (two) put(1'b1);
        end
        repeat (40 * DIV) @(posedge pclk);
    endtask
endmodule

`default_nettype wire

// File: tb/test_serial_relay_output_controller.sv
// Self-checking bench for the relay output controller.
`default_nettype none

module test_serial_relay_output_controller;
    timeunit 1ns;
    timeprecision 1ns;
    import relay_ctrl_pkg::*;

    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        rxd, pready, pslverr, nv_write;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [7:0]  nv_outputs_in = '0, nv_data, relay_out, v;
    logic [15:0] nv_init_in = '0;
    logic [32:0] expq [$];
    int          miscompares = 0, compares = 0;

    always #10 pclk = ~pclk;

    relay_output_ctrl #(.CLK_HZ(1000000), .TENTH_CYCLES(20)) relay_output_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd(rxd), .nv_outputs_in(nv_outputs_in), .nv_init_in(nv_init_in),
        .nv_write(nv_write), .nv_data(nv_data), .relay_out(relay_out));
    modbus_master_model #(.DIV(8)) modbus_master_model_i (.pclk(pclk), .rxd(rxd));

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request is held until pready is sampled high, then released.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Error flag and read data are compared with the oldest note.
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite) check({pslverr, prdata}, expq.pop_front());

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        complete_run();
    end

    initial begin
        void'($urandom(32'hD9D59246));
        nv_outputs_in <= 8'($urandom);
        nv_init_in <= 16'($urandom) | 16'h8000;
        v = 8'($urandom) | 8'hF0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        check(33'(relay_out), 33'(nv_outputs_in));
        rd(12'h170, 33'(nv_init_in & INIT_MASK));
        rd(12'h178, 33'h3);
        apb(1'b1, 12'h174, 32'h1106);
        apb(1'b1, 12'h178, 32'h7);
        rd(12'h174, 33'h1106);
        modbus_master_model_i.frame(8'h22, PAR_EVEN, 1'b1);
        rd(12'h200, 33'h0);
        modbus_master_model_i.frame(8'h11, PAR_EVEN, 1'b1);
        rd(12'h200, 33'h1);
        apb(1'b1, 12'h200, 32'hF);
        modbus_master_model_i.frame(8'h11, PAR_ODD, 1'b1);
        rd(12'h200, 33'h2);
        apb(1'b1, 12'h028, 32'(v));
        @(posedge pclk);
        check(33'({nv_write, nv_data, relay_out}), 33'({1'b1, v, v}));
        @(posedge pclk);
        check(33'(nv_write), 33'h0);
        rd(12'h010, 33'(v));
        apb(1'b1, 12'h170, 32'hC05A);
        repeat (100) @(posedge pclk);
        check(33'(relay_out), 33'(v));
        apb(1'b1, 12'h138, 32'h2);
        repeat (30) @(posedge pclk);
        check(33'(relay_out), 33'(v));
        repeat (30) @(posedge pclk);
        check(33'({nv_data, relay_out}), 33'h5A5A);
        rd(12'h200, 33'hA);
        apb(1'b1, 12'h1E0, 32'hFAC7);
        rd(12'h174, 33'h100);
        rd(12'h170, 33'h0);
        apb(1'b1, 12'h178, 32'h0);
        rd(12'h178, 33'h0);
        rd(12'h004, 33'h1_0000_0000);
        @(posedge pclk);
        complete_run();
    end
endmodule

`default_nettype wire
